// *** rtl/tlic_regs.vh ***
`ifndef TLIC_REGS_VH
`define TLIC_REGS_VH
// ****************************************
// Register byte offsets on the APB bus.
// ****************************************
`define TLIC_MAIN_OFS 12'h000
`define TLIC_EDGE_OFS 12'h004
`define TLIC_XLIN_OFS 12'h008
`define TLIC_RESET_CONTROL_REGISTER_OFS 12'h00C
`define TLIC_PFLG_OFS 12'h010
`define TLIC_PENA_OFS 12'h024
`define TLIC_PPRI_OFS 12'h038
`define TLIC_PER_PIN_CHANGE_ENABLE_OFS 12'h04C
`define TLIC_PER_PIN_PULLUP_ENABLE_OFS 12'h050
`define TLIC_TRIS_OFS 12'h054
`define TLIC_PORT_OFS 12'h058
`define TLIC_STAT_OFS 12'h05C
`define TLIC_PC_OFS 12'h060
// ****************************************
// Field positions.
// ****************************************
`define TLIC_GIE_BIT 7
`define TLIC_PEIE_BIT 6
`define TLIC_T0IE_BIT 5
`define TLIC_X0IE_BIT 4
`define TLIC_PCIE_BIT 3
`define TLIC_T0IF_BIT 2
`define TLIC_X0IF_BIT 1
`define TLIC_PCIF_BIT 0
`define TLIC_PUDIS_BIT 7
`define TLIC_EDG0_BIT 6
`define TLIC_EDG1_BIT 5
`define TLIC_EDG2_BIT 4
`define TLIC_T0IP_BIT 2
`define TLIC_PCIP_BIT 0
`define TLIC_X2IP_BIT 7
`define TLIC_X1IP_BIT 6
`define TLIC_X2IE_BIT 4
`define TLIC_X1IE_BIT 3
`define TLIC_X2IF_BIT 1
`define TLIC_X1IF_BIT 0
`define TLIC_PRIORITY_MODE_SELECT_BIT 7
// ****************************************
// Reset values, masks and vectors.
// ****************************************
`define TLIC_MAIN_RST 8'h00
`define TLIC_EDGE_RST 8'hF5
`define TLIC_XLIN_RST 8'hC0
`define TLIC_EDGE_MASK 8'hF5
`define TLIC_XLIN_MASK 8'hDB
`define TLIC_VEC_HIGH 16'h0008
`define TLIC_VEC_LOW 16'h0018
`define TLIC_NPER 5
// ****************************************
// Timing: event to vector in instruction cycles.
// ****************************************
`define TLIC_LAT_MIN 3
`define TLIC_LAT_MAX 4
`define TLIC_ACCEPT_DLY 2'd2
`endif

// *** rtl/tlic_edge_det.v ***
`timescale 1ns/1ns
// ****************************************
// Selectable edge detector for one external line.
// ****************************************
module tlic_edge_det
(
	// Clock and reset.
	input wire core_clk,
	input wire rstn,
	// Line and edge select.
	input wire line_in,
	input wire rising_sel,
	// Detected edge.
	output reg edge_pulse
);
	reg prev_reg;
	reg armed_reg;
	// The first cycle after reset only loads the line, so a pin idling high gives no false edge.
	always @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			prev_reg <= 1'b0;
			armed_reg <= 1'b0;
			edge_pulse <= 1'b0;
		end
		else
		begin
			prev_reg <= line_in;
			armed_reg <= 1'b1;
			edge_pulse <= armed_reg & (rising_sel ? (line_in & ~prev_reg) : (~line_in & prev_reg));
		end
	end
endmodule

// *** rtl/tlic_port_change.v ***
`timescale 1ns/1ns
// ****************************************
// Mismatch detector for the upper port B pins.
// ****************************************
module tlic_port_change
(
	// Clock and reset.
	input wire core_clk,
	input wire rstn,
	// Pins and control.
	input wire [3:0] upper_port_b_pins,
	input wire [3:0] per_pin_change_enable,
	input wire port_read,
	// Mismatch level.
	output wire mismatch
);
	// The latch only follows the pins on a port read, so a change holds the mismatch until software looks.
	reg [3:0] latch_reg;
	always @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			latch_reg <= 4'h0;
		else if (port_read)
			latch_reg <= upper_port_b_pins;
	end
	assign mismatch = |((latch_reg ^ upper_port_b_pins) & per_pin_change_enable);
endmodule

// *** rtl/tlic_top.v ***
// What this block does
// - Acceptance clears the enable of that level.
// - Priority mode splits globals into high, low.
// - High pre-empts low; low waits during high.
// - Push return address, load level's vector.
// - Return instruction re-enables the serviced level.
// - Pin events vector in three to four cycles; the code accepts on the second instruction boundary after the flag is seen.
// - Flags set regardless of the interrupt enable bits.
// - Bit 7 is global or high enable.
// - Bit 6 is peripheral or low enable.
// - Main control enables at bits 5,4,3.
// - Flags at bits 2,1,0, software cleared.
// - Port change mismatch keeps flag set until read.
// - Port change needs per-pin change enable.
// - Pull-up disable bit and per-pin pull-ups.
// - Edge select bits 6,5,4 rising or falling.
// - Timer and port change levels at 2, 0.
// - Third register holds line one, two fields.
// - Unimplemented bits read zero.
// - Five peripheral request flag registers.
// - Mode bit enables priority; else priorities ignored.
// - Compatibility mode always uses high vector.
// - External line zero is always high priority.
// - Vector when flag, enable, global all set.
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ns
`include "tlic_regs.vh"
module tlic_top
(
	// Clock and reset.
	input wire core_clk,
	input wire rstn,
	// APB slave.
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Event sources.
	input wire timer_zero_overflow,
	input wire ext_line_zero,
	input wire ext_line_one,
	input wire ext_line_two,
	input wire [7:0] port_b_pins,
	input wire [39:0] periph_events,
	// Core sequencer.
	input wire instr_cycle,
	input wire return_from_service_instr,
	input wire [15:0] return_addr,
	output reg vector_load,
	output reg [15:0] vector_addr,
	output reg stack_push,
	output reg [15:0] stack_data,
	// Port B pull-ups.
	output reg [7:0] pullup_on
);
	// ****************************************
	// Registers.
	// ****************************************
	reg [7:0] main_reg;
	reg [7:0] edge_reg;
	reg [7:0] xlin_reg;
	reg prio_mode_reg;
	reg [7:0] pflag_reg [0:`TLIC_NPER-1];
	reg [7:0] pena_reg [0:`TLIC_NPER-1];
	reg [7:0] ppri_reg [0:`TLIC_NPER-1];
	reg [7:0] per_pin_change_enable_reg;
	reg [7:0] per_pin_pullup_enable_reg;
	reg [7:0] tris_reg;
	reg in_high_reg;
	reg in_low_reg;
	reg [1:0] wait_reg;
	reg pend_high_reg;
	wire x0_edge;
	wire x1_edge;
	wire x2_edge;
	wire pc_mismatch;
	wire wr = psel & penable & pwrite;
	wire rd = psel & penable & ~pwrite;
	wire port_read = rd & (paddr == `TLIC_PORT_OFS);
	// Decoding used for both reads and writes: slot and in_bank; per_index is never called.
	function [3:0] per_index;
		input [11:0] a;
		begin
			per_index = 4'hF;
			if (a >= `TLIC_PFLG_OFS && a < `TLIC_PFLG_OFS + 12'h014)
				per_index = {1'b0, a[4:2]} - 4'd4;
			else if (a >= `TLIC_PENA_OFS && a < `TLIC_PENA_OFS + 12'h014)
				per_index = 4'h8 + {1'b0, slot(a, `TLIC_PENA_OFS)};
			else if (a >= `TLIC_PPRI_OFS && a < `TLIC_PPRI_OFS + 12'h014)
				per_index = 4'h0;
		end
	endfunction
	function [2:0] slot;
		input [11:0] a;
		input [11:0] base;
		reg [11:0] d;
		begin
			d = (a - base) >> 2;
			slot = d[2:0];
		end
	endfunction
	function in_bank;
		input [11:0] a;
		input [11:0] base;
		begin
			in_bank = (a >= base) && (a < base + 12'h014);
		end
	endfunction
	// ****************************************
	// Edge and port change detectors.
	// ****************************************
	tlic_edge_det u_x0 (.core_clk(core_clk), .rstn(rstn), .line_in(ext_line_zero),
		.rising_sel(edge_reg[`TLIC_EDG0_BIT]), .edge_pulse(x0_edge));
	tlic_edge_det u_x1 (.core_clk(core_clk), .rstn(rstn), .line_in(ext_line_one),
		.rising_sel(edge_reg[`TLIC_EDG1_BIT]), .edge_pulse(x1_edge));
	tlic_edge_det u_x2 (.core_clk(core_clk), .rstn(rstn), .line_in(ext_line_two),
		.rising_sel(edge_reg[`TLIC_EDG2_BIT]), .edge_pulse(x2_edge));
	tlic_port_change u_pc (.core_clk(core_clk), .rstn(rstn), .upper_port_b_pins(port_b_pins[7:4]),
		.per_pin_change_enable(per_pin_change_enable_reg[7:4]), .port_read(port_read), .mismatch(pc_mismatch));
	// ****************************************
	// Request combination.
	// ****************************************
	wire gie = main_reg[`TLIC_GIE_BIT];
	wire peie = main_reg[`TLIC_PEIE_BIT];
	wire t0_act = main_reg[`TLIC_T0IE_BIT] & main_reg[`TLIC_T0IF_BIT];
	wire x0_act = main_reg[`TLIC_X0IE_BIT] & main_reg[`TLIC_X0IF_BIT];
	wire pc_act = main_reg[`TLIC_PCIE_BIT] & main_reg[`TLIC_PCIF_BIT];
	wire x1_act = xlin_reg[`TLIC_X1IE_BIT] & xlin_reg[`TLIC_X1IF_BIT];
	wire x2_act = xlin_reg[`TLIC_X2IE_BIT] & xlin_reg[`TLIC_X2IF_BIT];
	wire [`TLIC_NPER-1:0] per_hi;
	wire [`TLIC_NPER-1:0] per_lo;
	genvar g;
	generate
		for (g = 0; g < `TLIC_NPER; g = g + 1)
		begin : g_per
			assign per_hi[g] = |(pflag_reg[g] & pena_reg[g] & ppri_reg[g]);
			assign per_lo[g] = |(pflag_reg[g] & pena_reg[g] & ~ppri_reg[g]);
		end
	endgenerate
	// Non-peripheral sources at each level; line zero is always high.
	wire core_hi = x0_act | (t0_act & edge_reg[`TLIC_T0IP_BIT]) | (pc_act & edge_reg[`TLIC_PCIP_BIT]) |
		(x1_act & xlin_reg[`TLIC_X1IP_BIT]) | (x2_act & xlin_reg[`TLIC_X2IP_BIT]);
	wire core_lo = (t0_act & ~edge_reg[`TLIC_T0IP_BIT]) | (pc_act & ~edge_reg[`TLIC_PCIP_BIT]) |
		(x1_act & ~xlin_reg[`TLIC_X1IP_BIT]) | (x2_act & ~xlin_reg[`TLIC_X2IP_BIT]);
	wire core_any = x0_act | t0_act | pc_act | x1_act | x2_act;
	wire per_any = |(per_hi | per_lo);
	// In compatibility mode priorities are ignored and everything goes high.
	wire req_hi = prio_mode_reg ? (gie & (core_hi | (|per_hi))) :
		(gie & (core_any | (peie & per_any)));
	wire req_lo = prio_mode_reg & gie & peie & (core_lo | (|per_lo));
	wire take_hi = req_hi & ~in_high_reg;
	wire take_lo = req_lo & ~in_high_reg & ~in_low_reg;
	// ****************************************
	// Vectoring sequencer.
	// ****************************************
	// Acceptance waits a fixed count on instruction boundaries so latency does not depend on instruction length.
	always @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wait_reg <= 2'd0;
			pend_high_reg <= 1'b0;
		end
		else if (wait_reg == 2'd0)
		begin
			if (take_hi | take_lo)
			begin
				wait_reg <= `TLIC_ACCEPT_DLY;
				pend_high_reg <= take_hi;
			end
		end
		else if (instr_cycle)
			wait_reg <= wait_reg - 2'd1;
	end
	wire accept = (wait_reg == 2'd1) & instr_cycle;
	always @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			vector_load <= 1'b0;
			vector_addr <= 16'h0000;
			stack_push <= 1'b0;
			stack_data <= 16'h0000;
			in_high_reg <= 1'b0;
			in_low_reg <= 1'b0;
		end
		else
		begin
			vector_load <= accept;
			stack_push <= accept;
			if (accept)
			begin
				stack_data <= return_addr;
				vector_addr <= (pend_high_reg | ~prio_mode_reg) ? `TLIC_VEC_HIGH : `TLIC_VEC_LOW;
				if (pend_high_reg)
					in_high_reg <= 1'b1;
				else
					in_low_reg <= 1'b1;
			end
			else if (return_from_service_instr)
			begin
				if (in_high_reg)
					in_high_reg <= 1'b0;
				else
					in_low_reg <= 1'b0;
			end
		end
	end
	// ****************************************
	// Register writes and flag setting.
	// ****************************************
	integer i;
	always @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			main_reg <= `TLIC_MAIN_RST;
			edge_reg <= `TLIC_EDGE_RST;
			xlin_reg <= `TLIC_XLIN_RST;
			prio_mode_reg <= 1'b0;
			per_pin_change_enable_reg <= 8'h00;
			per_pin_pullup_enable_reg <= 8'h00;
			tris_reg <= 8'hFF;
			for (i = 0; i < `TLIC_NPER; i = i + 1)
			begin
				pflag_reg[i] <= 8'h00;
				pena_reg[i] <= 8'h00;
				ppri_reg[i] <= 8'h00;
			end
		end
		else
		begin
			if (wr)
			begin
				case (paddr)
					`TLIC_MAIN_OFS: main_reg <= pwdata[7:0];
					`TLIC_EDGE_OFS: edge_reg <= pwdata[7:0] & `TLIC_EDGE_MASK;
					`TLIC_XLIN_OFS: xlin_reg <= pwdata[7:0] & `TLIC_XLIN_MASK;
					`TLIC_RESET_CONTROL_REGISTER_OFS: prio_mode_reg <= pwdata[`TLIC_PRIORITY_MODE_SELECT_BIT];
					`TLIC_PER_PIN_CHANGE_ENABLE_OFS: per_pin_change_enable_reg <= pwdata[7:0];
					`TLIC_PER_PIN_PULLUP_ENABLE_OFS: per_pin_pullup_enable_reg <= pwdata[7:0];
					`TLIC_TRIS_OFS: tris_reg <= pwdata[7:0];
					default:
					begin
						if (in_bank(paddr, `TLIC_PFLG_OFS))
							pflag_reg[slot(paddr, `TLIC_PFLG_OFS)] <= pwdata[7:0];
						if (in_bank(paddr, `TLIC_PENA_OFS))
							pena_reg[slot(paddr, `TLIC_PENA_OFS)] <= pwdata[7:0];
						if (in_bank(paddr, `TLIC_PPRI_OFS))
							ppri_reg[slot(paddr, `TLIC_PPRI_OFS)] <= pwdata[7:0];
					end
				endcase
			end
			// Enable clear on accept and set on return, then event sets: sets win over clears.
			if (accept)
			begin
				if (pend_high_reg | ~prio_mode_reg)
					main_reg[`TLIC_GIE_BIT] <= 1'b0;
				else
					main_reg[`TLIC_PEIE_BIT] <= 1'b0;
			end
			else if (return_from_service_instr)
			begin
				if (~prio_mode_reg | in_high_reg)
					main_reg[`TLIC_GIE_BIT] <= 1'b1;
				else
					main_reg[`TLIC_PEIE_BIT] <= 1'b1;
			end
			if (timer_zero_overflow)
				main_reg[`TLIC_T0IF_BIT] <= 1'b1;
			if (x0_edge)
				main_reg[`TLIC_X0IF_BIT] <= 1'b1;
			if (pc_mismatch)
				main_reg[`TLIC_PCIF_BIT] <= 1'b1;
			if (x1_edge)
				xlin_reg[`TLIC_X1IF_BIT] <= 1'b1;
			if (x2_edge)
				xlin_reg[`TLIC_X2IF_BIT] <= 1'b1;
			for (i = 0; i < `TLIC_NPER; i = i + 1)
				pflag_reg[i] <= (wr && in_bank(paddr, `TLIC_PFLG_OFS) && slot(paddr, `TLIC_PFLG_OFS) == i[2:0] ?
					pwdata[7:0] : pflag_reg[i]) | periph_events[i*8 +: 8];
		end
	end
	// ****************************************
	// Pull-ups and APB read side.
	// ****************************************
	reg [7:0] rd_byte;
	reg rd_hit;
	always @*
	begin
		rd_hit = 1'b1;
		rd_byte = 8'h00;
		case (paddr)
			`TLIC_MAIN_OFS: rd_byte = main_reg;
			`TLIC_EDGE_OFS: rd_byte = edge_reg & `TLIC_EDGE_MASK;
			`TLIC_XLIN_OFS: rd_byte = xlin_reg & `TLIC_XLIN_MASK;
			`TLIC_RESET_CONTROL_REGISTER_OFS: rd_byte = {prio_mode_reg, 7'h00};
			`TLIC_PER_PIN_CHANGE_ENABLE_OFS: rd_byte = per_pin_change_enable_reg;
			`TLIC_PER_PIN_PULLUP_ENABLE_OFS: rd_byte = per_pin_pullup_enable_reg;
			`TLIC_TRIS_OFS: rd_byte = tris_reg;
			`TLIC_PORT_OFS: rd_byte = port_b_pins;
			`TLIC_STAT_OFS: rd_byte = {4'h0, pend_high_reg, |wait_reg, in_low_reg, in_high_reg};
			`TLIC_PC_OFS: rd_byte = {7'h00, pc_mismatch};
			default:
			begin
				if (in_bank(paddr, `TLIC_PFLG_OFS))
					rd_byte = pflag_reg[slot(paddr, `TLIC_PFLG_OFS)];
				else if (in_bank(paddr, `TLIC_PENA_OFS))
					rd_byte = pena_reg[slot(paddr, `TLIC_PENA_OFS)];
				else if (in_bank(paddr, `TLIC_PPRI_OFS))
					rd_byte = ppri_reg[slot(paddr, `TLIC_PPRI_OFS)];
				else
					rd_hit = 1'b0;
			end
		endcase
	end
	always @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			pullup_on <= 8'h00;
		end
		else
		begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~rd_hit;
			if (psel & ~penable & ~pwrite)
				prdata <= {24'h00_0000, rd_byte};
			pullup_on <= edge_reg[`TLIC_PUDIS_BIT] ? 8'h00 : (per_pin_pullup_enable_reg & tris_reg);
		end
	end
endmodule

// *** bench/tlic_top_sva.sv ***
`timescale 1ns/1ns
module tlic_top_sva
(
	// Clock and reset.
	input wire core_clk,
	input wire rstn,
	// APB.
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Core side.
	input wire [15:0] return_addr,
	input wire vector_load,
	input wire [15:0] vector_addr,
	input wire stack_push,
	input wire [15:0] stack_data,
	input wire [7:0] pullup_on
);
	// Shadows follow completed writes only, so a refused or stalled access never moves them.
	reg priority_mode_select_reg;
	reg pud_reg;
	wire wr_done = psel && penable && pready && pwrite;
	always @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			priority_mode_select_reg <= 1'b0;
			pud_reg <= 1'b1;
		end
		else
		begin
			if (wr_done && paddr == 12'h00C)
				priority_mode_select_reg <= pwdata[7];
			if (wr_done && paddr == 12'h004)
				pud_reg <= pwdata[7];
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	chk_zero_wait: assert property (psel && penable |-> pready)
		else $error("access phase not answered at once");
	chk_ready_access: assert property (pready |-> psel && penable && $past(psel) && !$past(penable))
		else $error("ready outside access phase");
	chk_unmapped_err: assert property (psel && penable && paddr == 12'h100 |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	chk_unimpl_zero: assert property (pready && !pwrite && paddr == 12'h004 |-> prdata[3] == 1'b0 && prdata[1] == 1'b0)
		else $error("unimplemented bit reads one");
	chk_push_vector: assert property (vector_load |-> stack_push && stack_data == $past(return_addr))
		else $error("return address not pushed with vector");
	chk_vector_pulse: assert property (vector_load |-> (vector_addr == 16'h0008 || vector_addr == 16'h0018) ##1 !vector_load)
		else $error("bad vector load");
	chk_compat_high: assert property (!priority_mode_select_reg && vector_load |-> vector_addr == 16'h0008)
		else $error("compatibility mode used low vector");
	chk_pullup_off: assert property (pud_reg && $past(pud_reg) |-> pullup_on == 8'h00)
		else $error("pull-up active while disabled");
endmodule

bind tlic_top tlic_top_sva i_tlic_top_sva(.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.return_addr(return_addr), .vector_load(vector_load), .vector_addr(vector_addr), .stack_push(stack_push),
	.stack_data(stack_data), .pullup_on(pullup_on));

// *** bench/tlic_core_model.sv ***
`timescale 1ns/1ns
// ****************************************
// Core sequencer: instruction boundaries and program counter.
// ****************************************
module tlic_core_model
#(
	parameter int CYCLE_CLKS = 4
)
(
	// Clock and reset.
	input wire core_clk,
	input wire rstn,
	// Vector from the block.
	input wire vector_load,
	input wire [15:0] vector_addr,
	// Sequencer outputs.
	output reg instr_cycle,
	output reg [15:0] return_addr
);
	reg [7:0] div_reg;
	always @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			div_reg <= 8'h00;
			instr_cycle <= 1'b0;
			return_addr <= 16'h0100;
		end
		else
		begin
			div_reg <= (div_reg == CYCLE_CLKS - 1) ? 8'h00 : div_reg + 8'h01;
			instr_cycle <= (div_reg == CYCLE_CLKS - 1);
			// The address moves only on a jump, so a push can be compared against a stable value.
			if (vector_load)
				return_addr <= vector_addr + 16'h0010;
		end
	end
endmodule

// *** bench/tlic_top_bench.sv ***
`timescale 1ns/1ns
`include "tlic_regs.vh"
module tlic_top_bench;
	reg core_clk = 1'b0;
	reg rstn = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0;
	reg tmr = 1'b0;
	reg [2:0] xl = 3'b000;
	reg [7:0] pb = 8'h00;
	reg [39:0] pev = 40'h0;
	reg ret = 1'b0;
	wire [31:0] prdata;
	wire pready;
	wire pslverr;
	wire instr_cycle;
	wire [15:0] return_addr;
	wire vector_load;
	wire [15:0] vector_addr;
	wire stack_push;
	wire [15:0] stack_data;
	wire [7:0] pullup_on;
	reg [31:0] rd;
	reg er;
	integer fail_count = 0;
	integer num_checks = 0;
	integer ic;
	integer nvec = 0;
	integer nv;
	integer i;
	typedef struct packed {logic [11:0] a; logic w; logic [7:0] d; logic [7:0] x; logic e; logic [7:0] p;} tlic_row_t;
	tlic_row_t rows [0:10];
	always #25 core_clk = ~core_clk;
	always @(posedge core_clk)
		if (vector_load === 1'b1)
			nvec <= nvec + 1;
	tlic_top i_tlic_top(.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_zero_overflow(tmr), .ext_line_zero(xl[0]), .ext_line_one(xl[1]), .ext_line_two(xl[2]),
		.port_b_pins(pb), .periph_events(pev), .instr_cycle(instr_cycle), .return_from_service_instr(ret),
		.return_addr(return_addr), .vector_load(vector_load), .vector_addr(vector_addr),
		.stack_push(stack_push), .stack_data(stack_data), .pullup_on(pullup_on));
	tlic_core_model i_tlic_core_model(.core_clk(core_clk), .rstn(rstn), .vector_load(vector_load),
		.vector_addr(vector_addr), .instr_cycle(instr_cycle), .return_addr(return_addr));
	task check(input [31:0] got, input [31:0] exp);
	begin
		num_checks = num_checks + 1;
		if (got !== exp)
		begin
			fail_count = fail_count + 1;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task apb(input w, input [11:0] a, input [7:0] d);
		integer n;
	begin
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n = n + 1;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			check(32'h0, 32'h1);
	end
	endtask
	task rdchk(input [11:0] a, input [7:0] x);
	begin
		apb(1'b0, a, 8'h00);
		check(rd, {24'h0, x});
	end
	endtask
	task pulse_tmr;
	begin
		@(posedge core_clk);
		tmr <= 1'b1;
		@(posedge core_clk);
		tmr <= 1'b0;
	end
	endtask
	task pulse_ret;
	begin
		@(posedge core_clk);
		ret <= 1'b1;
		@(posedge core_clk);
		ret <= 1'b0;
	end
	endtask
	task setx(input [2:0] v);
	begin
		@(posedge core_clk);
		xl <= v;
		repeat (3) @(posedge core_clk);
	end
	endtask
	task wait_vec(input [15:0] exp);
		integer n;
	begin
		n = 0;
		ic = 0;
		do
		begin
			@(posedge core_clk);
			n = n + 1;
			ic = ic + (instr_cycle === 1'b1);
		end
		while (vector_load !== 1'b1 && n < 200);
		check({16'h0, vector_addr}, {16'h0, exp});
		check({16'h0, stack_data}, {16'h0, return_addr});
	end
	endtask
	task test_done;
	begin
		$display("checks %0d errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	initial
	begin
		#(50 * 20000);
		fail_count = fail_count + 1;
		test_done;
	end
	initial
	begin
		rows = '{{`TLIC_MAIN_OFS, 1'b0, 8'h00, 8'h00, 1'b0, 8'h00}, {`TLIC_EDGE_OFS, 1'b0, 8'h00, 8'hF5, 1'b0, 8'h00},
			{`TLIC_XLIN_OFS, 1'b0, 8'h00, 8'hC0, 1'b0, 8'h00}, {12'h100, 1'b1, 8'hFF, 8'h00, 1'b1, 8'h00},
			{`TLIC_EDGE_OFS, 1'b1, 8'hFF, 8'hF5, 1'b0, 8'h00}, {`TLIC_PER_PIN_PULLUP_ENABLE_OFS, 1'b1, 8'h0F, 8'h0F, 1'b0, 8'h00},
			{`TLIC_EDGE_OFS, 1'b1, 8'h75, 8'h75, 1'b0, 8'h0F}, {`TLIC_TRIS_OFS, 1'b1, 8'hFE, 8'hFE, 1'b0, 8'h0E},
			{`TLIC_EDGE_OFS, 1'b1, 8'hF5, 8'hF5, 1'b0, 8'h00}, {`TLIC_XLIN_OFS, 1'b1, 8'hD8, 8'hD8, 1'b0, 8'h00},
			{`TLIC_XLIN_OFS, 1'b1, 8'h00, 8'h00, 1'b0, 8'h00}};
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		for (i = 0; i < 11; i = i + 1)
		begin
			if (rows[i].w)
				apb(1'b1, rows[i].a, rows[i].d);
			apb(1'b0, rows[i].a, 8'h00);
			check(rd, {24'h0, rows[i].x});
			check({31'h0, er}, {31'h0, rows[i].e});
			check({24'h0, pullup_on}, {24'h0, rows[i].p});
		end
		// ****************************************
		// Flags, edge select and software clearing.
		// ****************************************
		setx(3'b111);
		rdchk(`TLIC_MAIN_OFS, 8'h02);
		rdchk(`TLIC_XLIN_OFS, 8'h03);
		setx(3'b000);
		apb(1'b1, `TLIC_MAIN_OFS, 8'h00);
		apb(1'b1, `TLIC_XLIN_OFS, 8'h00);
		apb(1'b1, `TLIC_EDGE_OFS, 8'h05);
		setx(3'b111);
		rdchk(`TLIC_MAIN_OFS, 8'h00);
		setx(3'b000);
		rdchk(`TLIC_XLIN_OFS, 8'h03);
		pulse_tmr;
		rdchk(`TLIC_MAIN_OFS, 8'h06);
		apb(1'b1, `TLIC_MAIN_OFS, 8'h00);
		apb(1'b1, `TLIC_XLIN_OFS, 8'h00);
		apb(1'b1, `TLIC_EDGE_OFS, 8'hF5);
		for (i = 0; i < 5; i = i + 1)
		begin
			pev[8 * i] <= 1'b1;
			@(posedge core_clk);
			pev[8 * i] <= 1'b0;
			rdchk(`TLIC_PFLG_OFS + 4 * i, 8'h01);
			apb(1'b1, `TLIC_PFLG_OFS + 4 * i, 8'h00);
		end
		// ****************************************
		// Port change mismatch.
		// ****************************************
		pb <= 8'h10;
		rdchk(`TLIC_MAIN_OFS, 8'h00);
		apb(1'b0, `TLIC_PORT_OFS, 8'h00);
		apb(1'b1, `TLIC_PER_PIN_CHANGE_ENABLE_OFS, 8'hFF);
		pb <= 8'h11;
		rdchk(`TLIC_MAIN_OFS, 8'h00);
		pb <= 8'h01;
		apb(1'b1, `TLIC_MAIN_OFS, 8'h00);
		rdchk(`TLIC_MAIN_OFS, 8'h01);
		apb(1'b0, `TLIC_PORT_OFS, 8'h00);
		apb(1'b1, `TLIC_MAIN_OFS, 8'h00);
		rdchk(`TLIC_MAIN_OFS, 8'h00);
		// ****************************************
		// Compatibility mode vectoring and return.
		// ****************************************
		apb(1'b1, `TLIC_MAIN_OFS, 8'hA0);
		pulse_tmr;
		wait_vec(16'h0008);
		rdchk(`TLIC_MAIN_OFS, 8'h24);
		apb(1'b1, `TLIC_MAIN_OFS, 8'h20);
		pulse_ret;
		rdchk(`TLIC_MAIN_OFS, 8'hA0);
		apb(1'b1, `TLIC_MAIN_OFS, 8'h90);
		@(posedge core_clk);
		xl <= 3'b001;
		wait_vec(16'h0008);
		check({31'h0, ic >= 2 && ic <= 4}, 32'h1);
		rdchk(`TLIC_MAIN_OFS, 8'h12);
		apb(1'b1, `TLIC_MAIN_OFS, 8'h00);
		pulse_ret;
		pev[0] <= 1'b1;
		apb(1'b1, `TLIC_PENA_OFS, 8'h01);
		pev[0] <= 1'b0;
		nv = nvec;
		apb(1'b1, `TLIC_MAIN_OFS, 8'h80);
		repeat (40) @(posedge core_clk);
		check(nvec, nv);
		apb(1'b1, `TLIC_MAIN_OFS, 8'hC0);
		wait_vec(16'h0008);
		rdchk(`TLIC_MAIN_OFS, 8'h40);
		apb(1'b1, `TLIC_PFLG_OFS, 8'h00);
		pulse_ret;
		apb(1'b1, `TLIC_MAIN_OFS, 8'h00);
		// ****************************************
		// Priority mode: low service pre-empted by high.
		// ****************************************
		xl <= 3'b000;
		apb(1'b1, `TLIC_RESET_CONTROL_REGISTER_OFS, 8'h80);
		apb(1'b1, `TLIC_EDGE_OFS, 8'hF1);
		apb(1'b1, `TLIC_MAIN_OFS, 8'hF0);
		pulse_tmr;
		wait_vec(16'h0018);
		rdchk(`TLIC_MAIN_OFS, 8'hB4);
		@(posedge core_clk);
		xl <= 3'b001;
		wait_vec(16'h0008);
		rdchk(`TLIC_MAIN_OFS, 8'h36);
		nv = nvec;
		apb(1'b1, `TLIC_MAIN_OFS, 8'h74);
		repeat (40) @(posedge core_clk);
		check(nvec, nv);
		apb(1'b1, `TLIC_MAIN_OFS, 8'h70);
		pulse_ret;
		rdchk(`TLIC_MAIN_OFS, 8'hF0);
		pulse_ret;
		rdchk(`TLIC_MAIN_OFS, 8'hF0);
		// ****************************************
		// Reset in mid-run.
		// ****************************************
		xl <= 3'b000;
		pb <= 8'h00;
		@(posedge core_clk);
		rstn <= 1'b0;
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		rdchk(`TLIC_MAIN_OFS, 8'h00);
		rdchk(`TLIC_EDGE_OFS, 8'hF5);
		rdchk(`TLIC_XLIN_OFS, 8'hC0);
		check({24'h0, pullup_on}, 32'h0);
		test_done;
	end
endmodule
